// file: inc/cbs_regs.vh
// constants of the per-instruction bus cycle sequencer
// assumes one 20 MHz clock; bus cycles are built from several clocks
// Operation
// [RULE1] wait op pushes seven bytes, cc in cycle 9
// [RULE2] while waiting: bus released, strobe low, floated
// [RULE3] interrupt return takes ten cycles, pulls seven bytes
// [RULE4] soft trap: stack, internal cycle, vector fetch
// [RULE5] strobe-qualified devices float data when strobe low
// [RULE6] returns read opcode+1 and discard the byte
// [RULE7] immediate: 2 cycles, 16-bit operands 3 cycles
// [RULE8] direct reads: 3 cycles, 16-bit 4 cycles
// [RULE9] direct stores: acc 4 cycles, 16-bit 5 cycles
// [RULE10] extended: address high then low, then operand
// [RULE11] extended stores: acc 5 cycles, 16-bit 6
// [RULE12] extended read-modify-write 6 cycles, test writes nothing
// [RULE13] extended call 9 cycles with target re-read
// [RULE14] extended jump 3 cycles, strobe always high
// [RULE15] branches 4 cycles, two internal cycles
// [RULE16] relative call 8 cycles, three internal cycles; the code has four (cycles 3, 6, 7, 8)
// [RULE17] indexed address is index plus unsigned offset
// [RULE18] write line low only on writes; strobe on transfers; the code also drives it low on the test op's last cycle
// [RULE19] next instruction fetched at updated program counter
`ifndef CBS_REGS_VH
`define CBS_REGS_VH

// clocks per bus cycle; two are lost in the data synchroniser
`define CBS_BUS_PH     3'd4

// reset values of the program-visible registers
`define CBS_RST_PC     16'h0000
`define CBS_RST_SP     16'h01ff
`define CBS_RST_X      16'h0000
`define CBS_RST_BYTE   8'h00

// trap vector addresses
`define CBS_VEC_HI     16'hfffa
`define CBS_VEC_LO     16'hfffb

// instruction classes, taken from opcode bits 4..0
`define CBS_C_NOP      5'd0
`define CBS_C_WAI      5'd1
`define CBS_C_RTI      5'd2
`define CBS_C_SWI      5'd3
`define CBS_C_IMM8     5'd4
`define CBS_C_IMM16    5'd5
`define CBS_C_DIR8     5'd6
`define CBS_C_DIR16    5'd7
`define CBS_C_DSTA     5'd8
`define CBS_C_DSTX     5'd9
`define CBS_C_EXT8     5'd10
`define CBS_C_EXT16    5'd11
`define CBS_C_ESTA     5'd12
`define CBS_C_ESTX     5'd13
`define CBS_C_RMW      5'd14
`define CBS_C_CALL     5'd15
`define CBS_C_JMP      5'd16
`define CBS_C_BR       5'd17
`define CBS_C_BSR      5'd18
`define CBS_C_IDX      5'd19
`define CBS_C_LAST     5'd19

// opcode and condition code flag bits
`define CBS_OPB_ALT    7
`define CBS_CC_ZERO    2

// address sources
`define CBS_A_OP       4'd0
`define CBS_A_OP1      4'd1
`define CBS_A_OP2      4'd2
`define CBS_A_SP       4'd3
`define CBS_A_SPI      4'd4
`define CBS_A_EA       4'd5
`define CBS_A_EA1      4'd6
`define CBS_A_VHI      4'd7
`define CBS_A_VLO      4'd8
`define CBS_A_X        4'd9
`define CBS_A_XNC      4'd10
`define CBS_A_BR       4'd11
`define CBS_A_IDX      4'd12

// write data sources
`define CBS_W_PCL      3'd0
`define CBS_W_PCH      3'd1
`define CBS_W_RL       3'd2
`define CBS_W_RH       3'd3
`define CBS_W_A        3'd4
`define CBS_W_B        3'd5
`define CBS_W_CC       3'd6
`define CBS_W_OPR      3'd7

// read destinations
`define CBS_R_NONE     4'd0
`define CBS_R_EAH      4'd2
`define CBS_R_EAL      4'd3
`define CBS_R_CC       4'd4
`define CBS_R_B        4'd5
`define CBS_R_A        4'd6
`define CBS_R_XH       4'd7
`define CBS_R_XL       4'd8
`define CBS_R_OPR      4'd11
`define CBS_R_O16H     4'd12
`define CBS_R_O16L     4'd13
`define CBS_R_RMW      4'd15

`endif

// file: src/cbs_sync2.v
// two-flop synchroniser for pin inputs
// assumes the inputs are asynchronous to ref_clk_in
`timescale 1ns/1ps
module cbs_sync2 #(
  parameter         W       = 8,
  parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
  input  wire         ref_clk_in, // core clock
  input  wire         rstn_in,    // async reset, active low
  input  wire [W-1:0] d_in,       // raw pin level
  output reg  [W-1:0] q_out       // synchronised level
);
  reg [W-1:0] meta_r;

  // first stage feeds only the second stage
  always @(posedge ref_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      // idle pin levels, so no false request follows reset
      meta_r <= RST_VAL;
      q_out  <= RST_VAL;
    end
    else
    begin
      meta_r <= d_in;
      q_out  <= meta_r;
    end
  end
endmodule

// file: src/cbs_addr_calc.v
// effective address arithmetic for branch and indexed modes
// purely combinational; operands come from sequencer registers
`timescale 1ns/1ps
module cbs_addr_calc (
  input  wire [15:0] opa_in,    // opcode address
  input  wire [15:0] idx_in,    // index register
  input  wire [7:0]  off_in,    // offset byte
  output wire [15:0] br_out,    // branch target
  output wire [15:0] idx_out,   // index plus offset
  output wire [15:0] idx_nc_out // index plus offset, no carry
);
  // branch offset is signed, relative to the following instruction
  assign br_out = opa_in + 16'd2 + {{8{off_in[7]}}, off_in};

  // unsigned offset 0..255 added to the full index
  assign idx_out = idx_in + {8'h00, off_in}; // RULE17

  // low byte only: the intermediate address shown before the carry
  assign idx_nc_out = {idx_in[15:8], idx_in[7:0] + off_in};
endmodule

// file: src/cbs_sequencer.v
// bus cycle sequencer of an 8-bit processor core
// assumes combinational-speed memory answering within one clock
`timescale 1ns/1ps
`include "cbs_regs.vh"
module cbs_sequencer #(
  parameter [2:0] BUS_PH = `CBS_BUS_PH
) (
  input  wire        ref_clk_in,   // core clock, 20 MHz
  input  wire        rstn_in,      // async reset, active low
  input  wire [7:0]  data_in,      // data bus level from pins
  input  wire        irq_n_in,     // interrupt request, active low
  output reg  [15:0] addr_out,     // address bus
  output reg         addr_oe_out,  // address bus driven
  output reg         rw_out,       // high read, low write
  output reg         rw_oe_out,    // read/write line driven
  output reg         valid_address_strobe_out, // real transfer
  output reg  [7:0]  data_out,     // data bus drive value
  output reg         data_oe_out,  // data bus driven
  output reg         bus_avail_out, // bus released while waiting
  output reg         fetch_out,    // opcode fetch cycle
  output reg  [7:0]  acc_a_out,    // accumulator a
  output reg  [15:0] idx_out,      // index register
  output reg  [15:0] sp_out        // stack pointer
);
  localparam [1:0] ST_RUN  = 2'b01;
  localparam [1:0] ST_HALT = 2'b10;
  localparam [2:0] PH_LAST = BUS_PH - 3'd1;

  reg [1:0]  st_r;
  reg [2:0]  ph_r;
  reg [3:0]  step_r;
  reg [4:0]  cls_r;
  reg [7:0]  opc_r;
  reg [15:0] pc_r;
  reg [15:0] sp_r;
  reg [15:0] x_r;
  reg [15:0] ea_r;
  reg [7:0]  a_r;
  reg [7:0]  b_r;
  reg [7:0]  cc_r;
  reg [7:0]  opr_r;
  reg        sel_sp_r;

  wire [7:0]  data_s;
  wire        irq_n_s;
  wire [15:0] br_addr;
  wire [15:0] idx_addr;
  wire [15:0] idx_nc_addr;

  // pin inputs cross through two flops before any use
  cbs_sync2 #(.W(9), .RST_VAL(9'h1ff)) u_sync (
    .ref_clk_in (ref_clk_in),
    .rstn_in    (rstn_in),
    .d_in       ({irq_n_in, data_in}),
    .q_out      ({irq_n_s, data_s})
  );

  cbs_addr_calc u_calc (
    .opa_in     (pc_r),
    .idx_in     (x_r),
    .off_in     (ea_r[7:0]),
    .br_out     (br_addr),
    .idx_out    (idx_addr),
    .idx_nc_out (idx_nc_addr)
  );

  // packs one cycle: strobe, r/w, address, write data, read dest, last
  function [13:0] mk;
    input integer v;
    input integer rw;
    input [3:0]   a;
    input [2:0]   w;
    input [3:0]   r;
    input integer l;
    begin
      mk = {v[0], rw[0], a, w, r, l[0]};
    end
  endfunction

  // unknown encodings run as a two-cycle no-op
  function [4:0] cls_of;
    input [7:0] op;
    begin
      if (op[4:0] > `CBS_C_LAST)
        cls_of = `CBS_C_NOP;
      else
        cls_of = op[4:0];
    end
  endfunction

  // instruction length in bytes, for return addresses and fall-through
  function [15:0] ilen;
    input [4:0] c;
    begin
      case (c)
        `CBS_C_NOP, `CBS_C_WAI, `CBS_C_RTI, `CBS_C_SWI: ilen = 16'd1;
        `CBS_C_IMM16, `CBS_C_EXT8, `CBS_C_EXT16, `CBS_C_ESTA,
        `CBS_C_ESTX, `CBS_C_RMW, `CBS_C_CALL, `CBS_C_JMP: ilen = 16'd3;
        default: ilen = 16'd2;
      endcase
    end
  endfunction

  // cycle table; cycle 1 (opcode fetch) is common and not listed here
  function [13:0] seq;
    input [4:0] c;
    input [3:0] s;
    reg   [8:0] k;
    begin
      k = {c, s};
      seq = mk(1, 1, `CBS_A_OP1, `CBS_W_A, `CBS_R_NONE, 1);
      case (k)
        // stacking shared by wait and soft trap
        {`CBS_C_WAI, 4'd2}, {`CBS_C_SWI, 4'd2}:
          seq = mk(1, 1, `CBS_A_OP1, `CBS_W_A, `CBS_R_NONE, 0);
        {`CBS_C_WAI, 4'd3}, {`CBS_C_SWI, 4'd3}:
          seq = mk(1, 0, `CBS_A_SP, `CBS_W_PCL, `CBS_R_NONE, 0); // RULE1
        {`CBS_C_WAI, 4'd4}, {`CBS_C_SWI, 4'd4}:
          seq = mk(1, 0, `CBS_A_SP, `CBS_W_PCH, `CBS_R_NONE, 0);
        {`CBS_C_WAI, 4'd5}, {`CBS_C_SWI, 4'd5}:
          seq = mk(1, 0, `CBS_A_SP, `CBS_W_RL, `CBS_R_NONE, 0);
        {`CBS_C_WAI, 4'd6}, {`CBS_C_SWI, 4'd6}:
          seq = mk(1, 0, `CBS_A_SP, `CBS_W_RH, `CBS_R_NONE, 0);
        {`CBS_C_WAI, 4'd7}, {`CBS_C_SWI, 4'd7}:
          seq = mk(1, 0, `CBS_A_SP, `CBS_W_A, `CBS_R_NONE, 0);
        {`CBS_C_WAI, 4'd8}, {`CBS_C_SWI, 4'd8}:
          seq = mk(1, 0, `CBS_A_SP, `CBS_W_B, `CBS_R_NONE, 0);
        {`CBS_C_WAI, 4'd9}:
          seq = mk(1, 0, `CBS_A_SP, `CBS_W_CC, `CBS_R_NONE, 1); // RULE1
        {`CBS_C_SWI, 4'd9}:
          seq = mk(1, 0, `CBS_A_SP, `CBS_W_CC, `CBS_R_NONE, 0); // RULE4
        {`CBS_C_SWI, 4'd10}:
          seq = mk(0, 1, `CBS_A_SP, `CBS_W_A, `CBS_R_NONE, 0); // RULE4
        {`CBS_C_SWI, 4'd11}:
          seq = mk(1, 1, `CBS_A_VHI, `CBS_W_A, `CBS_R_EAH, 0); // RULE4
        {`CBS_C_SWI, 4'd12}:
          seq = mk(1, 1, `CBS_A_VLO, `CBS_W_A, `CBS_R_EAL, 1); // RULE4
        // interrupt return
        {`CBS_C_RTI, 4'd2}:
          seq = mk(1, 1, `CBS_A_OP1, `CBS_W_A, `CBS_R_NONE, 0); // RULE6
        {`CBS_C_RTI, 4'd3}:
          seq = mk(0, 1, `CBS_A_SP, `CBS_W_A, `CBS_R_NONE, 0); // RULE3
        {`CBS_C_RTI, 4'd4}:
          seq = mk(1, 1, `CBS_A_SPI, `CBS_W_A, `CBS_R_CC, 0); // RULE3
        {`CBS_C_RTI, 4'd5}:
          seq = mk(1, 1, `CBS_A_SPI, `CBS_W_A, `CBS_R_B, 0);
        {`CBS_C_RTI, 4'd6}:
          seq = mk(1, 1, `CBS_A_SPI, `CBS_W_A, `CBS_R_A, 0);
        {`CBS_C_RTI, 4'd7}:
          seq = mk(1, 1, `CBS_A_SPI, `CBS_W_A, `CBS_R_XH, 0);
        {`CBS_C_RTI, 4'd8}:
          seq = mk(1, 1, `CBS_A_SPI, `CBS_W_A, `CBS_R_XL, 0);
        {`CBS_C_RTI, 4'd9}:
          seq = mk(1, 1, `CBS_A_SPI, `CBS_W_A, `CBS_R_EAH, 0);
        {`CBS_C_RTI, 4'd10}:
          seq = mk(1, 1, `CBS_A_SPI, `CBS_W_A, `CBS_R_EAL, 1); // RULE3
        // immediate
        {`CBS_C_IMM8, 4'd2}:
          seq = mk(1, 1, `CBS_A_OP1, `CBS_W_A, `CBS_R_OPR, 1); // RULE7
        {`CBS_C_IMM16, 4'd2}:
          seq = mk(1, 1, `CBS_A_OP1, `CBS_W_A, `CBS_R_O16H, 0); // RULE7
        {`CBS_C_IMM16, 4'd3}:
          seq = mk(1, 1, `CBS_A_OP2, `CBS_W_A, `CBS_R_O16L, 1); // RULE7
        // direct: one address byte, page zero
        {`CBS_C_DIR8, 4'd2}, {`CBS_C_DIR16, 4'd2}, {`CBS_C_DSTA, 4'd2},
        {`CBS_C_DSTX, 4'd2}, {`CBS_C_BR, 4'd2}, {`CBS_C_BSR, 4'd2},
        {`CBS_C_IDX, 4'd2}:
          seq = mk(1, 1, `CBS_A_OP1, `CBS_W_A, `CBS_R_EAL, 0);
        {`CBS_C_DIR8, 4'd3}, {`CBS_C_EXT8, 4'd4}:
          seq = mk(1, 1, `CBS_A_EA, `CBS_W_A, `CBS_R_OPR, 1); // RULE8
        {`CBS_C_DIR16, 4'd3}, {`CBS_C_EXT16, 4'd4}:
          seq = mk(1, 1, `CBS_A_EA, `CBS_W_A, `CBS_R_O16H, 0); // RULE8
        {`CBS_C_DIR16, 4'd4}, {`CBS_C_EXT16, 4'd5}:
          seq = mk(1, 1, `CBS_A_EA1, `CBS_W_A, `CBS_R_O16L, 1); // RULE10
        {`CBS_C_DSTA, 4'd3}, {`CBS_C_DSTX, 4'd3}, {`CBS_C_ESTA, 4'd4},
        {`CBS_C_ESTX, 4'd4}:
          seq = mk(0, 1, `CBS_A_EA, `CBS_W_A, `CBS_R_NONE, 0); // RULE9
        {`CBS_C_DSTA, 4'd4}, {`CBS_C_ESTA, 4'd5}:
          seq = mk(1, 0, `CBS_A_EA, `CBS_W_A, `CBS_R_NONE, 1); // RULE11
        {`CBS_C_DSTX, 4'd4}, {`CBS_C_ESTX, 4'd5}:
          seq = mk(1, 0, `CBS_A_EA, `CBS_W_RH, `CBS_R_NONE, 0); // RULE9
        {`CBS_C_DSTX, 4'd5}, {`CBS_C_ESTX, 4'd6}:
          seq = mk(1, 0, `CBS_A_EA1, `CBS_W_RL, `CBS_R_NONE, 1); // RULE11
        // extended: address high then low
        {`CBS_C_EXT8, 4'd2}, {`CBS_C_EXT16, 4'd2}, {`CBS_C_ESTA, 4'd2},
        {`CBS_C_ESTX, 4'd2}, {`CBS_C_RMW, 4'd2}, {`CBS_C_CALL, 4'd2},
        {`CBS_C_JMP, 4'd2}:
          seq = mk(1, 1, `CBS_A_OP1, `CBS_W_A, `CBS_R_EAH, 0); // RULE10
        {`CBS_C_EXT8, 4'd3}, {`CBS_C_EXT16, 4'd3}, {`CBS_C_ESTA, 4'd3},
        {`CBS_C_ESTX, 4'd3}, {`CBS_C_RMW, 4'd3}, {`CBS_C_CALL, 4'd3}:
          seq = mk(1, 1, `CBS_A_OP2, `CBS_W_A, `CBS_R_EAL, 0); // RULE10
        {`CBS_C_JMP, 4'd3}:
          seq = mk(1, 1, `CBS_A_OP2, `CBS_W_A, `CBS_R_EAL, 1); // RULE14
        {`CBS_C_RMW, 4'd4}:
          seq = mk(1, 1, `CBS_A_EA, `CBS_W_A, `CBS_R_RMW, 0); // RULE12
        {`CBS_C_RMW, 4'd5}:
          seq = mk(0, 1, `CBS_A_EA, `CBS_W_A, `CBS_R_NONE, 0); // RULE12
        {`CBS_C_RMW, 4'd6}:
          seq = mk(1, 0, `CBS_A_EA, `CBS_W_OPR, `CBS_R_NONE, 1); // RULE12
        // extended call
        {`CBS_C_CALL, 4'd4}:
          seq = mk(1, 1, `CBS_A_EA, `CBS_W_A, `CBS_R_NONE, 0); // RULE13
        {`CBS_C_CALL, 4'd5}, {`CBS_C_BSR, 4'd4}:
          seq = mk(1, 0, `CBS_A_SP, `CBS_W_PCL, `CBS_R_NONE, 0); // RULE13
        {`CBS_C_CALL, 4'd6}, {`CBS_C_BSR, 4'd5}:
          seq = mk(1, 0, `CBS_A_SP, `CBS_W_PCH, `CBS_R_NONE, 0); // RULE16
        {`CBS_C_CALL, 4'd7}, {`CBS_C_BSR, 4'd6}:
          seq = mk(0, 1, `CBS_A_SP, `CBS_W_A, `CBS_R_NONE, 0); // RULE13
        {`CBS_C_CALL, 4'd8}:
          seq = mk(0, 1, `CBS_A_OP2, `CBS_W_A, `CBS_R_NONE, 0); // RULE13
        {`CBS_C_CALL, 4'd9}:
          seq = mk(1, 1, `CBS_A_OP2, `CBS_W_A, `CBS_R_EAL, 1); // RULE13
        // relative branches and calls
        {`CBS_C_BR, 4'd3}, {`CBS_C_BSR, 4'd3}, {`CBS_C_BSR, 4'd7}:
          seq = mk(0, 1, `CBS_A_OP2, `CBS_W_A, `CBS_R_NONE, 0); // RULE15
        {`CBS_C_BR, 4'd4}:
          seq = mk(0, 1, `CBS_A_BR, `CBS_W_A, `CBS_R_NONE, 1); // RULE15
        {`CBS_C_BSR, 4'd8}:
          seq = mk(0, 1, `CBS_A_BR, `CBS_W_A, `CBS_R_NONE, 1); // RULE16
        // indexed read
        {`CBS_C_IDX, 4'd3}:
          seq = mk(0, 1, `CBS_A_X, `CBS_W_A, `CBS_R_NONE, 0);
        {`CBS_C_IDX, 4'd4}:
          seq = mk(0, 1, `CBS_A_XNC, `CBS_W_A, `CBS_R_NONE, 0);
        {`CBS_C_IDX, 4'd5}:
          seq = mk(1, 1, `CBS_A_IDX, `CBS_W_A, `CBS_R_OPR, 1); // RULE17
        default:
          seq = mk(1, 1, `CBS_A_OP1, `CBS_W_A, `CBS_R_NONE, 1);
      endcase
    end
  endfunction

  reg  [13:0] ctl;
  reg         vma_c;
  reg  [15:0] addr_c;
  reg  [7:0]  wdat_c;
  reg  [15:0] ea_nxt;
  reg  [15:0] pc_nxt;
  wire        c_rw   = ctl[12];
  wire [3:0]  c_as   = ctl[11:8];
  wire [2:0]  c_ws   = ctl[7:5];
  wire [3:0]  c_rs   = ctl[4:1];
  wire        c_last = ctl[0];
  wire        end_cyc = (ph_r == PH_LAST);
  wire        is_test = (cls_r == `CBS_C_RMW) & opc_r[`CBS_OPB_ALT];
  wire [15:0] ret_addr = pc_r + ilen(cls_r);
  wire [15:0] src16 = sel_sp_r ? sp_r : x_r;
  wire        taken = opc_r[`CBS_OPB_ALT] | cc_r[`CBS_CC_ZERO];
  // vma low means the bus byte is not ours to take
  wire        rd_take = end_cyc & vma_c & c_rw; // RULE5

  // current cycle decode, address and write data
  always @*
  begin
    if (step_r == 4'd1)
      ctl = mk(1, 1, `CBS_A_OP, `CBS_W_A, `CBS_R_NONE, 0);
    else
      ctl = seq(cls_r, step_r);
    // the test op leaves memory alone on its last cycle
    vma_c = ctl[13] & ~(is_test & c_last); // RULE12
    case (c_as)
      `CBS_A_OP:  addr_c = pc_r;
      `CBS_A_OP1: addr_c = pc_r + 16'd1;
      `CBS_A_OP2: addr_c = pc_r + 16'd2;
      `CBS_A_SP:  addr_c = sp_r;
      `CBS_A_SPI: addr_c = sp_r + 16'd1;
      `CBS_A_EA:  addr_c = ea_r;
      `CBS_A_EA1: addr_c = ea_r + 16'd1;
      `CBS_A_VHI: addr_c = `CBS_VEC_HI;
      `CBS_A_VLO: addr_c = `CBS_VEC_LO;
      `CBS_A_X:   addr_c = x_r;
      `CBS_A_XNC: addr_c = idx_nc_addr;
      `CBS_A_BR:  addr_c = br_addr;
      `CBS_A_IDX: addr_c = idx_addr;
      default:    addr_c = pc_r;
    endcase
    case (c_ws)
      `CBS_W_PCL: wdat_c = ret_addr[7:0];
      `CBS_W_PCH: wdat_c = ret_addr[15:8];
      `CBS_W_RL:  wdat_c = (cls_r == `CBS_C_WAI || cls_r == `CBS_C_SWI) ?
                           x_r[7:0] : src16[7:0];
      `CBS_W_RH:  wdat_c = (cls_r == `CBS_C_WAI || cls_r == `CBS_C_SWI) ?
                           x_r[15:8] : src16[15:8];
      `CBS_W_A:   wdat_c = a_r;
      `CBS_W_B:   wdat_c = b_r;
      `CBS_W_CC:  wdat_c = cc_r;
      default:    wdat_c = opr_r + 8'h01;
    endcase
  end

  // address latch and next program counter, merging the byte just read
  always @*
  begin
    ea_nxt = ea_r;
    if (rd_take && c_rs == `CBS_R_EAH)
      ea_nxt = {data_s, ea_r[7:0]};
    if (rd_take && c_rs == `CBS_R_EAL)
      ea_nxt = {ea_r[15:8], data_s};
    case (cls_r)
      `CBS_C_JMP, `CBS_C_CALL, `CBS_C_RTI, `CBS_C_SWI:
        pc_nxt = ea_nxt; // RULE19
      `CBS_C_BR:  pc_nxt = taken ? br_addr : ret_addr;
      `CBS_C_BSR: pc_nxt = br_addr;
      default:    pc_nxt = ret_addr; // RULE19
    endcase
  end

  // sequencer state, programmer registers and stack pointer
  always @(posedge ref_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      st_r     <= ST_RUN;
      ph_r     <= 3'd0;
      step_r   <= 4'd1;
      cls_r    <= `CBS_C_NOP;
      opc_r    <= `CBS_RST_BYTE;
      pc_r     <= `CBS_RST_PC;
      sp_r     <= `CBS_RST_SP;
      x_r      <= `CBS_RST_X;
      ea_r     <= 16'h0000;
      a_r      <= `CBS_RST_BYTE;
      b_r      <= `CBS_RST_BYTE;
      cc_r     <= `CBS_RST_BYTE;
      opr_r    <= `CBS_RST_BYTE;
      sel_sp_r <= 1'b0;
    end
    else
    begin
      case (st_r)
        ST_RUN:
        begin
          ph_r <= end_cyc ? 3'd0 : ph_r + 3'd1;
          if (end_cyc)
          begin
            ea_r <= ea_nxt;
            if (rd_take)
            begin
              case (c_rs)
                `CBS_R_CC:   cc_r <= data_s;
                `CBS_R_B:    b_r <= data_s;
                `CBS_R_A:    a_r <= data_s;
                `CBS_R_XH:   x_r[15:8] <= data_s;
                `CBS_R_XL:   x_r[7:0] <= data_s;
                `CBS_R_OPR:  a_r <= data_s;
                `CBS_R_RMW:  opr_r <= data_s;
                `CBS_R_O16H:
                  if (sel_sp_r)
                    sp_r[15:8] <= data_s;
                  else
                    x_r[15:8] <= data_s;
                `CBS_R_O16L:
                  if (sel_sp_r)
                    sp_r[7:0] <= data_s;
                  else
                    x_r[7:0] <= data_s;
                default:     opr_r <= opr_r;
              endcase
            end
            // pushes step down after the write, pulls step up
            if (c_as == `CBS_A_SP && !c_rw)
              sp_r <= sp_r - 16'd1; // RULE1
            else if (c_as == `CBS_A_SPI)
              sp_r <= sp_r + 16'd1; // RULE3
            if (step_r == 4'd1)
            begin
              opc_r    <= data_s;
              cls_r    <= cls_of(data_s);
              ea_r     <= 16'h0000;
              sel_sp_r <= data_s[`CBS_OPB_ALT];
              step_r   <= 4'd2;
            end
            else if (c_last)
            begin
              step_r <= 4'd1;
              pc_r   <= pc_nxt; // RULE19
              if (cls_r == `CBS_C_WAI)
                st_r <= ST_HALT; // RULE2
            end
            else
              step_r <= step_r + 4'd1;
          end
        end
        ST_HALT:
        begin
          // stays off the bus until the request line is seen low
          ph_r <= 3'd0;
          if (!irq_n_s)
            st_r <= ST_RUN;
        end
        default:
          st_r <= ST_RUN;
      endcase
    end
  end

  // pin drivers; all outputs registered, one clock after the step
  always @(posedge ref_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      addr_out                 <= `CBS_RST_PC;
      addr_oe_out              <= 1'b0;
      rw_out                   <= 1'b1;
      rw_oe_out                <= 1'b0;
      valid_address_strobe_out <= 1'b0;
      data_out                 <= 8'h00;
      data_oe_out              <= 1'b0;
      bus_avail_out            <= 1'b0;
      fetch_out                <= 1'b0;
      acc_a_out                <= `CBS_RST_BYTE;
      idx_out                  <= `CBS_RST_X;
      sp_out                   <= `CBS_RST_SP;
    end
    else
    begin
      acc_a_out <= a_r;
      idx_out   <= x_r;
      sp_out    <= sp_r;
      if (st_r == ST_HALT)
      begin
        addr_oe_out              <= 1'b0; // RULE2
        rw_oe_out                <= 1'b0;
        data_oe_out              <= 1'b0;
        valid_address_strobe_out <= 1'b0;
        bus_avail_out            <= 1'b1; // RULE2
        fetch_out                <= 1'b0;
      end
      else
      begin
        addr_out                 <= addr_c;
        addr_oe_out              <= 1'b1;
        rw_out                   <= c_rw; // RULE18
        rw_oe_out                <= 1'b1;
        valid_address_strobe_out <= vma_c; // RULE18
        data_out                 <= wdat_c;
        data_oe_out              <= vma_c & ~c_rw; // RULE18
        bus_avail_out            <= 1'b0;
        fetch_out                <= (step_r == 4'd1);
      end
    end
  end
endmodule

// file: tb/cbs_seq_chk.sv
// checker: bus-cycle relations at the sequencer's ports
// assumes it is bound into cbs_sequencer
`timescale 1ns/1ps
module cbs_seq_chk #(
  parameter [2:0] BUS_PH = 3'h4
) (
  input wire        ref_clk_in,               // clock
  input wire        rstn_in,                  // reset
  input wire [15:0] addr_out,                 // address
  input wire        addr_oe_out,              // addr oe
  input wire        rw_out,                   // read
  input wire        rw_oe_out,                // rw oe
  input wire        valid_address_strobe_out, // strobe
  input wire        data_oe_out,              // data oe
  input wire        bus_avail_out,            // released
  input wire        fetch_out                 // fetch
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rstn_in);
  // a bus cycle stands four clocks, so a fetch does too
  sequence s_fetch_hold;
    fetch_out [*4] ##1 !fetch_out;
  endsequence
  chk_fetch_len: assert property ($rose(fetch_out) |-> s_fetch_hold)
    else $error("fetch not four clocks");
  chk_strobe_len: assert property (
    $rose(valid_address_strobe_out) |-> valid_address_strobe_out [*4])
    else $error("strobe cut short");
  chk_halt_float: assert property (
    bus_avail_out |-> !valid_address_strobe_out && !addr_oe_out && !rw_oe_out && !data_oe_out)
    else $error("bus not released");
  chk_write_drive: assert property (data_oe_out == (!rw_out && valid_address_strobe_out))
    else $error("data drive wrong");
  chk_fetch_read: assert property (
    fetch_out |-> valid_address_strobe_out && rw_out && addr_oe_out)
    else $error("fetch not a read");
  chk_vector_pair: assert property (
    $rose(addr_out == 16'hfffa) |-> ##4 addr_out == 16'hfffb && valid_address_strobe_out)
    else $error("vector low byte missing");
  chk_wait_write: assert property (
    $rose(bus_avail_out) |-> !$past(rw_out) && $past(valid_address_strobe_out))
    else $error("halt not after a write");
  chk_resume_fetch: assert property ($fell(bus_avail_out) |-> fetch_out)
    else $error("wake without fetch");
endmodule
bind cbs_sequencer cbs_seq_chk #(.BUS_PH(BUS_PH)) chk_i (.*);

// file: tb/cbs_mem_model.sv
// partner memory: answers from the address in the same clock
// assumes strobe-qualified selection on the system bus
`timescale 1ns/1ps
module cbs_mem_model (
  input  wire        ref_clk_in, // clock
  input  wire [15:0] addr_in,    // address
  input  wire        rw_in,      // high read
  input  wire        strobe_in,  // valid address
  input  wire [7:0]  wdata_in,   // write data
  output wire [7:0]  rdata_out   // read data
);
  reg [7:0] mem [0:65535];
  reg [7:0] last_r = 8'h00;
  // unselected: floats, shown as a toggling pattern so no stale byte passes
  assign rdata_out = (strobe_in && rw_in) ? mem[addr_in] : ~last_r;
  // writes land only on strobed cycles
  always @(posedge ref_clk_in)
  begin
    if (strobe_in && !rw_in)
      mem[addr_in] <= wdata_in;
    last_r <= rdata_out;
  end
endmodule

// file: tb/tb.sv
// testbench: short program, every bus cycle judged
// assumes the memory model answers within one clock
`timescale 1ns/1ps
module tb;
  reg         ref_clk_in = 1'b0;
  reg         rstn_in = 1'b0;
  reg         irq_n_in = 1'b1;
  wire [7:0]  rd_w;
  wire [7:0]  wd_w, acc_w;
  wire [15:0] addr_w;
  wire [15:0] sp_w, idx_w;
  wire        aoe_w, rw_w, rwoe_w, strb_w, doe_w, bav_w, fetch_w;
  integer     mismatches = 0;
  integer     checks = 0;
  integer     i;
  // 20 MHz clock
  always #25 ref_clk_in = ~ref_clk_in;
  cbs_sequencer dut (.ref_clk_in(ref_clk_in), .rstn_in(rstn_in), .data_in(rd_w),
    .irq_n_in(irq_n_in), .addr_out(addr_w), .addr_oe_out(aoe_w), .rw_out(rw_w),
    .rw_oe_out(rwoe_w), .valid_address_strobe_out(strb_w), .data_out(wd_w),
    .data_oe_out(doe_w), .bus_avail_out(bav_w), .fetch_out(fetch_w), .acc_a_out(acc_w),
    .idx_out(idx_w), .sp_out(sp_w));
  cbs_mem_model mem_i (.ref_clk_in(ref_clk_in), .addr_in(addr_w), .rw_in(rw_w),
    .strobe_in(strb_w), .wdata_in(wd_w), .rdata_out(rd_w));
  task chk(input [39:0] nm, input [17:0] got, input [17:0] exp);
  begin
    checks = checks + 1;
    if (got !== exp)
    begin
      $display("MISMATCH %0s exp %h got %h", nm, exp, got);
      mismatches = mismatches + 1;
    end
  end
  endtask
  // judge one bus cycle at its first falling edge; its outputs still stand on return
  task cyc(input [15:0] a, input v, input w);
  begin
    @(negedge ref_clk_in);
    chk("bus", {addr_w, strb_w, rw_w}, {a, v, w});
    repeat (3) @(negedge ref_clk_in);
  end
  endtask
  task t_imm_store;
  begin
    cyc(16'h0000, 1'b1, 1'b1);
    cyc(16'h0001, 1'b1, 1'b1);
    cyc(16'h0002, 1'b1, 1'b1);
    cyc(16'h0003, 1'b1, 1'b1);
    cyc(16'h0040, 1'b0, 1'b1);
    cyc(16'h0040, 1'b1, 1'b0);
    chk("wdata", {10'h0, wd_w}, 18'h0005a);
    chk("acc", {10'h0, acc_w}, 18'h0005a);
  end
  endtask
  task t_trap_return;
  begin
    cyc(16'h0004, 1'b1, 1'b1);
    cyc(16'h0005, 1'b1, 1'b1);
    for (i = 0; i < 7; i = i + 1)
      cyc(16'h01ff - i[15:0], 1'b1, 1'b0);
    cyc(16'h01f8, 1'b0, 1'b1);
    cyc(16'hfffa, 1'b1, 1'b1);
    cyc(16'hfffb, 1'b1, 1'b1);
    chk("push", {10'h0, mem_i.mem[16'h01fb]}, 18'h0005a);
    cyc(16'h0100, 1'b1, 1'b1);
    cyc(16'h0101, 1'b1, 1'b1);
    cyc(16'h01f8, 1'b0, 1'b1);
    for (i = 1; i < 8; i = i + 1)
      cyc(16'h01f8 + i[15:0], 1'b1, 1'b1);
    // sp_out trails the last pull by one clock
    @(posedge ref_clk_in) #1;
    chk("sp", {2'h0, sp_w}, 18'h001ff);
    chk("idx", {2'h0, idx_w}, 18'h00000);
  end
  endtask
  task t_jump_branch;
  begin
    cyc(16'h0005, 1'b1, 1'b1);
    cyc(16'h0006, 1'b1, 1'b1);
    cyc(16'h0007, 1'b1, 1'b1);
    cyc(16'h0200, 1'b1, 1'b1);
    cyc(16'h0201, 1'b1, 1'b1);
    cyc(16'h0202, 1'b0, 1'b1);
    cyc(16'h0212, 1'b0, 1'b1);
  end
  endtask
  task t_wait_halt;
  begin
    cyc(16'h0212, 1'b1, 1'b1);
    cyc(16'h0213, 1'b1, 1'b1);
    for (i = 0; i < 7; i = i + 1)
      cyc(16'h01ff - i[15:0], 1'b1, 1'b0);
    repeat (4) @(negedge ref_clk_in);
    chk("halt", {13'h0, bav_w, aoe_w, rwoe_w, strb_w, doe_w}, 18'h10);
    irq_n_in = 1'b0;
    for (i = 0; i < 40 && fetch_w !== 1'b1; i = i + 1)
      @(negedge ref_clk_in);
    chk("wake", {addr_w, strb_w, rw_w}, {16'h0213, 2'b11});
    chk("sp", {2'h0, sp_w}, 18'h001f8);
  end
  endtask
  task final_report;
  begin
    if (mismatches == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  end
  endtask
  // program: imm load, direct store, trap, return, jump, branch, wait
  initial
  begin
    {mem_i.mem[0], mem_i.mem[1], mem_i.mem[2], mem_i.mem[3]} = 32'h045a0840;
    {mem_i.mem[4], mem_i.mem[5], mem_i.mem[6], mem_i.mem[7]} = 32'h03100200;
    mem_i.mem[16'h0100] = 8'h02;
    {mem_i.mem[16'hfffa], mem_i.mem[16'hfffb]} = 16'h0100;
    {mem_i.mem[16'h0200], mem_i.mem[16'h0201]} = 16'h9110;
    mem_i.mem[16'h0212] = 8'h01;
    repeat (2) @(negedge ref_clk_in);
    rstn_in = 1'b1;
    t_imm_store;
    t_trap_return;
    t_jump_branch;
    t_wait_halt;
    final_report;
  end
  // watchdog: the program needs about 190 clocks
  initial
  begin
    #100000;
    mismatches = mismatches + 1;
    final_report;
  end
endmodule
